// file: include/srh_pkg.sv
// constants and types of the status reporting hierarchy
package srh_pkg;
    // sub-register geometry
    localparam int SUB_W = 16;
    localparam int N_SUB = 2;
    localparam int SUB_SEL_W = 1;
    localparam int SUB_QUES = 0;
    localparam int SUB_OPER = 1;
    localparam logic [SUB_W-1:0] SUB_VALID_MASK = 16'h7fff;
    // sub-register reset values
    localparam logic [SUB_W-1:0] RISE_RST = 16'h7fff;
    localparam logic [SUB_W-1:0] FALL_RST = 16'h0000;
    localparam logic [SUB_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [SUB_W-1:0] EVENT_RST = 16'h0000;
    // status byte layout
    localparam int BYTE_W = 8;
    localparam int BYTE_ERRQ = 2;
    localparam int BYTE_QUES = 3;
    localparam int BYTE_MSG = 4;
    localparam int BYTE_STD = 5;
    localparam int BYTE_MASTER = 6;
    localparam int BYTE_OPER = 7;
    localparam logic [BYTE_W-1:0] SRQ_USE_MASK = 8'hbf;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [BYTE_W-1:0] SRQ_MASK_RST = 8'h00;
    localparam logic [BYTE_W-1:0] STD_MASK_RST = 8'h00;
    localparam logic [BYTE_W-1:0] STD_EVENT_RST = 8'h00;
    localparam logic [SUB_W-1:0] RDATA_RST = 16'h0000;
    // commands from the message layer
    typedef enum logic [3:0] {
        CMD_NONE, CMD_SRQ_MASK_WR, CMD_SRQ_MASK_RD, CMD_BYTE_RD, CMD_SERIAL_POLL,
        CMD_STD_MASK_WR, CMD_STD_MASK_RD, CMD_STD_EVENT_RD, CMD_SUB_WR, CMD_SUB_RD
    } srh_cmd_e;
    // parts of one sub-register
    typedef enum logic [2:0] {
        PART_COND, PART_RISE, PART_FALL, PART_EVENT, PART_ENABLE
    } srh_part_e;
endpackage : srh_pkg

// file: include/srh_sub_if.sv
// carrier between the hierarchy top and one sub-register
`timescale 1ns/1ps
interface srh_sub_if #(parameter int W = srh_pkg::SUB_W);
    logic [W-1:0] cond;
    logic [W-1:0] wdata;
    logic rise_we;
    logic fall_we;
    logic enable_we;
    logic event_rd;
    logic [W-1:0] event_q;
    logic [W-1:0] rise_q;
    logic [W-1:0] fall_q;
    logic [W-1:0] enable_q;
    logic summary;
    modport sub (input cond, wdata, rise_we, fall_we, enable_we, event_rd,
                 output event_q, rise_q, fall_q, enable_q, summary);
    modport ctl (output cond, wdata, rise_we, fall_we, enable_we, event_rd,
                 input event_q, rise_q, fall_q, enable_q, summary);
endinterface : srh_sub_if

// file: hdl/srh_sub_register.sv
// one sixteen-bit status sub-register with filters, latch and mask
`timescale 1ns/1ps
module srh_sub_register #(
    parameter int W = srh_pkg::SUB_W
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    srh_sub_if.sub bus
);
    import srh_pkg::*;

    logic [W-1:0] valid;
    logic [W-1:0] cond_prev_q;
    logic [W-1:0] ev_set;

    // top bit never set in any part
    assign valid = W'(SUB_VALID_MASK);
    // edge filters pick which transitions are latched
    assign ev_set = ((bus.cond & ~cond_prev_q & bus.rise_q)
                   | (~bus.cond & cond_prev_q & bus.fall_q)) & valid;
    // masked OR of latched events
    assign bus.summary = |(bus.event_q & bus.enable_q);

    // previous live state for edge detection
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cond_prev_q <= '0;
        end else begin
            cond_prev_q <= bus.cond & valid;
        end
    end

    // latched events, cleared by a read; a new event wins
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.event_q <= W'(EVENT_RST);
        end else if (bus.event_rd) begin
            bus.event_q <= ev_set;
        end else begin
            bus.event_q <= bus.event_q | ev_set;
        end
    end

    // writable filter and mask parts
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.rise_q <= W'(RISE_RST);
            bus.fall_q <= W'(FALL_RST);
            bus.enable_q <= W'(ENABLE_RST);
        end else begin
            if (bus.rise_we) bus.rise_q <= bus.wdata & valid;
            if (bus.fall_we) bus.fall_q <= bus.wdata & valid;
            if (bus.enable_we) bus.enable_q <= bus.wdata & valid;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // a filtered rising edge lands in the latch
    property p_rise_latched;
        (bus.cond[0] && !cond_prev_q[0] && bus.rise_q[0]) |=> bus.event_q[0];
    endproperty
    a_rise_latched: assert property (p_rise_latched) else $error("rise not latched");
    // a filtered falling edge lands in the latch
    property p_fall_latched;
        (!bus.cond[0] && cond_prev_q[0] && bus.fall_q[0]) |=> bus.event_q[0];
    endproperty
    a_fall_latched: assert property (p_fall_latched) else $error("fall not latched");
    // a read empties the latch except for same-cycle events
    property p_read_clears;
        bus.event_rd |=> bus.event_q == $past(ev_set);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");
    // top bit stays zero
    property p_top_zero;
        !bus.event_q[W-1] && !bus.rise_q[W-1] && !bus.fall_q[W-1] && !bus.enable_q[W-1];
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("top bit set");
    c_read_clear: cover property (bus.event_q != '0 ##1 bus.event_rd ##1 bus.event_q == '0);
endmodule : srh_sub_register

// file: hdl/srh_status_top.sv
// status reporting hierarchy: sub-registers, status byte, service request
// Summary of operation
// - filters choose none, rising, falling or both
// - latch keeps filtered events, cleared on read
// - mask part writable, read leaves it unchanged
// - sub summaries feed status byte live bits
// - byte bit 6 summarises other bits
// - byte returned on query and serial poll
// - request mask bit 6 ignored
// - masked zero-to-one byte change raises request
// - request mask written and read back
// - error queue bit 2, each entry re-requests
// - bit 3 is doubtful-state summary
// - bit 4 shows output message pending
// - bit 5 is standard event summary
// - bit 6 set while any masked other bit is set
// - bit 7 is activity summary
// - parts sixteen bits, top bit zero
// - live part follows hardware, read-only
// - rising uses rising filter, falling falling
`timescale 1ns/1ps
module srh_status_top (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [srh_pkg::N_SUB-1:0][srh_pkg::SUB_W-1:0] sub_cond_i,
    input wire logic [srh_pkg::BYTE_W-1:0] std_event_set_i,
    input wire logic err_queue_nonempty_i,
    input wire logic err_entry_i,
    input wire logic output_message_pending_i,
    input wire logic cmd_valid_i,
    input wire srh_pkg::srh_cmd_e cmd_i,
    input wire logic [srh_pkg::SUB_SEL_W-1:0] sub_sel_i,
    input wire srh_pkg::srh_part_e part_i,
    input wire logic [srh_pkg::SUB_W-1:0] wdata_i,
    output logic [srh_pkg::SUB_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic [srh_pkg::BYTE_W-1:0] summary_status_byte_o,
    output logic srq_o
);
    import srh_pkg::*;

    logic [N_SUB-1:0] sub_summary;
    logic [N_SUB-1:0][SUB_W-1:0] sub_rd_val;
    logic [N_SUB-1:0] sub_rd_ok;
    logic sub_wr;
    logic sub_rd;
    logic [BYTE_W-1:0] service_request_mask_q;
    logic [BYTE_W-1:0] standard_event_mask_q;
    logic [BYTE_W-1:0] standard_event_q;
    logic standard_event_summary;
    logic [BYTE_W-1:0] byte_base;
    logic [BYTE_W-1:0] byte_prev_q;
    logic [BYTE_W-1:0] byte_d;
    logic master_request_summary;
    logic srq_trig;
    logic serial_poll;
    logic [SUB_W-1:0] rdata_d;
    logic rvalid_d;

    // decode of sub-register accesses and serial poll
    assign sub_wr = cmd_valid_i && (cmd_i == CMD_SUB_WR);
    assign sub_rd = cmd_valid_i && (cmd_i == CMD_SUB_RD);
    assign serial_poll = cmd_valid_i && (cmd_i == CMD_SERIAL_POLL);

    // one sub-register per summary source
    for (genvar g = 0; g < N_SUB; g++) begin : g_sub
        logic sel;
        srh_sub_if #(.W(SUB_W)) sub_if ();

        assign sel = (sub_sel_i == SUB_SEL_W'(g));
        // live state straight from hardware
        assign sub_if.cond = sub_cond_i[g];
        assign sub_if.wdata = wdata_i;
        assign sub_if.rise_we = sub_wr && sel && (part_i == PART_RISE);
        assign sub_if.fall_we = sub_wr && sel && (part_i == PART_FALL);
        assign sub_if.enable_we = sub_wr && sel && (part_i == PART_ENABLE);
        assign sub_if.event_rd = sub_rd && sel && (part_i == PART_EVENT);
        assign sub_summary[g] = sub_if.summary;

        // read-back of the selected part
        always_comb begin
            sub_rd_val[g] = '0;
            sub_rd_ok[g] = 1'b1;
            unique case (part_i)
                PART_COND: sub_rd_val[g] = sub_if.cond & SUB_VALID_MASK;
                PART_RISE: sub_rd_val[g] = sub_if.rise_q;
                PART_FALL: sub_rd_val[g] = sub_if.fall_q;
                PART_EVENT: sub_rd_val[g] = sub_if.event_q;
                PART_ENABLE: sub_rd_val[g] = sub_if.enable_q;
                default: sub_rd_ok[g] = 1'b0;
            endcase
        end

        srh_sub_register #(.W(SUB_W)) u_sub (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .bus(sub_if)
        );
    end

    // standard event latch, cleared on read; new events win
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            standard_event_q <= STD_EVENT_RST;
        end else if (cmd_valid_i && (cmd_i == CMD_STD_EVENT_RD)) begin
            standard_event_q <= std_event_set_i;
        end else begin
            standard_event_q <= standard_event_q | std_event_set_i;
        end
    end

    // standard event mask
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            standard_event_mask_q <= STD_MASK_RST;
        end else if (cmd_valid_i && (cmd_i == CMD_STD_MASK_WR)) begin
            standard_event_mask_q <= wdata_i[BYTE_W-1:0];
        end
    end

    // service request mask keeps all eight bits as written
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            service_request_mask_q <= SRQ_MASK_RST;
        end else if (cmd_valid_i && (cmd_i == CMD_SRQ_MASK_WR)) begin
            service_request_mask_q <= wdata_i[BYTE_W-1:0];
        end
    end

    // standard event summary
    assign standard_event_summary = |(standard_event_q & standard_event_mask_q);

    // status byte sources apart from the master bit
    always_comb begin
        byte_base = '0;
        byte_base[BYTE_ERRQ] = err_queue_nonempty_i;
        byte_base[BYTE_QUES] = sub_summary[SUB_QUES];
        byte_base[BYTE_MSG] = output_message_pending_i;
        byte_base[BYTE_STD] = standard_event_summary;
        byte_base[BYTE_OPER] = sub_summary[SUB_OPER];
    end

    // master bit summarises masked other bits, mask bit 6 unused
    assign master_request_summary =
        |(byte_base & service_request_mask_q & SRQ_USE_MASK);

    // full byte with master bit
    always_comb begin
        byte_d = byte_base;
        byte_d[BYTE_MASTER] = master_request_summary;
    end

    // masked zero-to-one change or new queue entry
    assign srq_trig =
        (|(byte_base & ~byte_prev_q & service_request_mask_q & SRQ_USE_MASK))
        || (err_entry_i && service_request_mask_q[BYTE_ERRQ]);

    // status byte register and edge history
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            summary_status_byte_o <= BYTE_RST;
            byte_prev_q <= BYTE_RST;
        end else begin
            summary_status_byte_o <= byte_d;
            byte_prev_q <= byte_base;
        end
    end

    // request line: set wins, dropped by poll or when cause is gone
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            srq_o <= 1'b0;
        end else if (srq_trig) begin
            srq_o <= 1'b1;
        end else if (serial_poll || !master_request_summary) begin
            srq_o <= 1'b0;
        end
    end

    // read data selection
    always_comb begin
        rdata_d = RDATA_RST;
        rvalid_d = 1'b0;
        if (cmd_valid_i) begin
            unique case (cmd_i)
                CMD_SRQ_MASK_RD: begin
                    rdata_d = SUB_W'(service_request_mask_q);
                    rvalid_d = 1'b1;
                end
                CMD_BYTE_RD, CMD_SERIAL_POLL: begin
                    rdata_d = SUB_W'(summary_status_byte_o);
                    rvalid_d = 1'b1;
                end
                CMD_STD_MASK_RD: begin
                    rdata_d = SUB_W'(standard_event_mask_q);
                    rvalid_d = 1'b1;
                end
                CMD_STD_EVENT_RD: begin
                    rdata_d = SUB_W'(standard_event_q);
                    rvalid_d = 1'b1;
                end
                CMD_SUB_RD: begin
                    rdata_d = sub_rd_val[sub_sel_i];
                    rvalid_d = sub_rd_ok[sub_sel_i];
                end
                default: begin
                    rvalid_d = 1'b0;
                end
            endcase
        end
    end

    // registered read answer
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= RDATA_RST;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= rdata_d;
            rvalid_o <= rvalid_d;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // master bit follows masked other bits
    property p_master_bit;
        1 |=> summary_status_byte_o[BYTE_MASTER] == $past(master_request_summary);
    endproperty
    a_master_bit: assert property (p_master_bit) else $error("master bit wrong");

    // master bit agrees with the other bits of the byte it sits in
    property p_master_consistent;
        (service_request_mask_q == $past(service_request_mask_q)) |->
            summary_status_byte_o[BYTE_MASTER] ==
            |(summary_status_byte_o & $past(service_request_mask_q) & SRQ_USE_MASK);
    endproperty
    a_master_consistent: assert property (p_master_consistent) else $error("master mismatch");

    // only mask bit 6 set never requests
    property p_mask6_ignored;
        ((service_request_mask_q & SRQ_USE_MASK) == '0) |=> !srq_o;
    endproperty
    a_mask6_ignored: assert property (p_mask6_ignored) else $error("bit 6 mask used");

    // masked message bit rising raises the request next cycle
    property p_msg_rise_srq;
        ($rose(output_message_pending_i) && service_request_mask_q[BYTE_MSG]) |=> srq_o;
    endproperty
    a_msg_rise_srq: assert property (p_msg_rise_srq) else $error("no request on rise");

    // every enabled queue entry requests again
    property p_err_entry_srq;
        (err_entry_i && service_request_mask_q[BYTE_ERRQ]) |=> srq_o;
    endproperty
    a_err_entry_srq: assert property (p_err_entry_srq) else $error("entry lost");

    // serial poll and query return the byte one cycle later
    property p_poll_returns_byte;
        (cmd_valid_i && (cmd_i inside {CMD_SERIAL_POLL, CMD_BYTE_RD})) |=>
            rvalid_o && (rdata_o == SUB_W'($past(summary_status_byte_o)));
    endproperty
    a_poll_returns_byte: assert property (p_poll_returns_byte) else $error("poll data bad");

    // mask write then read returns the written value
    property p_mask_readback;
        (cmd_valid_i && (cmd_i == CMD_SRQ_MASK_WR)) ##1
            (cmd_valid_i && (cmd_i == CMD_SRQ_MASK_RD)) |=>
            rdata_o[BYTE_W-1:0] == $past(wdata_i[BYTE_W-1:0], 2);
    endproperty
    a_mask_readback: assert property (p_mask_readback) else $error("mask readback bad");

    // source bits copied into the byte after one cycle
    property p_byte_sources;
        1 |=> summary_status_byte_o[BYTE_MSG] == $past(output_message_pending_i)
            && summary_status_byte_o[BYTE_QUES] == $past(sub_summary[SUB_QUES])
            && summary_status_byte_o[BYTE_OPER] == $past(sub_summary[SUB_OPER])
            && summary_status_byte_o[BYTE_STD] == $past(standard_event_summary)
            && summary_status_byte_o[BYTE_ERRQ] == $past(err_queue_nonempty_i);
    endproperty
    a_byte_sources: assert property (p_byte_sources) else $error("byte source bad");

    // low two bits always zero
    property p_low_zero;
        summary_status_byte_o[1:0] == 2'h0;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("unused bits set");

    // mask query returns stored byte
    property p_srq_mask_query;
        (cmd_valid_i && (cmd_i == CMD_SRQ_MASK_RD)) |=>
            rvalid_o && (rdata_o == SUB_W'($past(service_request_mask_q)));
    endproperty
    a_srq_mask_query: assert property (p_srq_mask_query) else $error("mask query bad");

    // event mask query returns stored byte
    property p_std_mask_query;
        (cmd_valid_i && (cmd_i == CMD_STD_MASK_RD)) |=>
            rvalid_o && (rdata_o == SUB_W'($past(standard_event_mask_q)));
    endproperty
    a_std_mask_query: assert property (p_std_mask_query) else $error("event mask bad");

    // poll drops the request unless a new cause comes
    property p_poll_clears;
        (serial_poll && !srq_trig) |=> !srq_o;
    endproperty
    a_poll_clears: assert property (p_poll_clears) else $error("poll kept request");

    // no request without a cause
    property p_srq_cause;
        (!srq_trig && !master_request_summary) |=> !srq_o;
    endproperty
    a_srq_cause: assert property (p_srq_cause) else $error("request without cause");

    // queue not empty shows in bit 2
    property p_errq_bit;
        err_queue_nonempty_i |=> summary_status_byte_o[BYTE_ERRQ];
    endproperty
    a_errq_bit: assert property (p_errq_bit) else $error("queue bit low");

    // doubtful summary shows in bit 3
    property p_ques_bit;
        sub_summary[SUB_QUES] |=> summary_status_byte_o[BYTE_QUES];
    endproperty
    a_ques_bit: assert property (p_ques_bit) else $error("doubtful bit low");

    // activity summary shows in bit 7
    property p_oper_bit;
        sub_summary[SUB_OPER] |=> summary_status_byte_o[BYTE_OPER];
    endproperty
    a_oper_bit: assert property (p_oper_bit) else $error("activity bit low");

    // writes give no read answer
    property p_write_silent;
        (cmd_valid_i && (cmd_i inside {CMD_SRQ_MASK_WR, CMD_STD_MASK_WR, CMD_SUB_WR})) |=>
            !rvalid_o;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write answered");

    c_srq: cover property ($rose(srq_o));
    c_poll: cover property (srq_o ##1 serial_poll ##1 !srq_o);
    c_std_summary: cover property ($rose(summary_status_byte_o[BYTE_STD]));
    c_oper_summary: cover property ($rose(summary_status_byte_o[BYTE_OPER]));
endmodule : srh_status_top

// file: test/srh_ctl_model.sv
// behavioural bus controller: issues commands and serves requests
`timescale 1ns/1ps
module srh_ctl_model (
    input wire logic ref_clk_i,
    output logic cmd_valid_o,
    output srh_pkg::srh_cmd_e cmd_o,
    output logic [srh_pkg::SUB_SEL_W-1:0] sub_sel_o,
    output srh_pkg::srh_part_e part_o,
    output logic [srh_pkg::SUB_W-1:0] wdata_o,
    input wire logic [srh_pkg::SUB_W-1:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic srq_i
);
    import srh_pkg::*;
    logic [SUB_W-1:0] last_rdata;
    logic last_rvalid;
    logic auto_poll;
    int poll_delay;
    logic [BYTE_W-1:0] polled_byte;
    // request lines idle at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = CMD_NONE;
        sub_sel_o = 1'b0;
        part_o = PART_COND;
        wdata_o = 16'h0000;
        auto_poll = 1'b0;
        poll_delay = 0;
    end
    // one command, held until the answering edge, data scrambled after
    task automatic xfer(input srh_cmd_e c, input logic [SUB_SEL_W-1:0] s,
                        input srh_part_e p, input logic [SUB_W-1:0] d);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o = c;
        sub_sel_o = s;
        part_o = p;
        wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        last_rvalid = rvalid_i;
        last_rdata = rdata_i;
        cmd_valid_o = 1'b0;
        cmd_o = CMD_NONE;
        wdata_o = ~d;
    endtask : xfer
    // two commands on consecutive edges, second answer kept
    task automatic xfer2(input srh_cmd_e c1, input srh_cmd_e c2, input logic [SUB_W-1:0] d);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o = c1;
        wdata_o = d;
        @(posedge ref_clk_i);
        #1;
        cmd_o = c2;
        @(posedge ref_clk_i);
        #1;
        last_rvalid = rvalid_i;
        last_rdata = rdata_i;
        cmd_valid_o = 1'b0;
        cmd_o = CMD_NONE;
    endtask : xfer2
    // service routine: serial poll after a delay while a request stands
    always begin
        @(posedge ref_clk_i);
        #1;
        if (auto_poll && srq_i === 1'b1) begin
            repeat (poll_delay) @(posedge ref_clk_i);
            xfer(CMD_SERIAL_POLL, 1'b0, PART_COND, 16'h0000);
            polled_byte = last_rdata[BYTE_W-1:0];
        end
    end
endmodule : srh_ctl_model

// file: test/testbench.sv
// self-checking bench of the status reporting hierarchy
`timescale 1ns/1ps
module testbench;
    import srh_pkg::*;
    typedef struct packed {
        logic [7:0] mask;
        logic msg;
        logic errq;
        logic [7:0] exp_byte;
        logic exp_srq;
    } srh_row_s;
    logic ref_clk_i = 1'b0;
    logic rstn_i;
    logic [N_SUB-1:0][SUB_W-1:0] cond;
    logic [BYTE_W-1:0] sev;
    logic eqn;
    logic een;
    logic omp;
    logic cv;
    srh_cmd_e cmd;
    logic [SUB_SEL_W-1:0] sel;
    srh_part_e part;
    logic [SUB_W-1:0] wd;
    logic [SUB_W-1:0] rdata_o;
    logic rvalid_o;
    logic [BYTE_W-1:0] byte_o;
    logic srq_o;
    int err_count = 0;
    int num_checks = 0;
    srh_row_s rows [6] = '{
        '{8'h00, 1'b1, 1'b0, 8'h10, 1'b0},
        '{8'h10, 1'b1, 1'b0, 8'h50, 1'b1},
        '{8'h40, 1'b1, 1'b0, 8'h10, 1'b0},
        '{8'h04, 1'b0, 1'b1, 8'h44, 1'b1},
        '{8'h0c, 1'b1, 1'b1, 8'h54, 1'b1},
        '{8'hff, 1'b0, 1'b0, 8'h00, 1'b0}};
    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;
    srh_status_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sub_cond_i(cond),
        .std_event_set_i(sev), .err_queue_nonempty_i(eqn), .err_entry_i(een),
        .output_message_pending_i(omp), .cmd_valid_i(cv), .cmd_i(cmd), .sub_sel_i(sel),
        .part_i(part), .wdata_i(wd), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .summary_status_byte_o(byte_o), .srq_o(srq_o));
    srh_ctl_model ctl (.ref_clk_i(ref_clk_i), .cmd_valid_o(cv), .cmd_o(cmd),
        .sub_sel_o(sel), .part_o(part), .wdata_o(wd), .rdata_i(rdata_o),
        .rvalid_i(rvalid_o), .srq_i(srq_o));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic wr(input srh_cmd_e c, input int s, input srh_part_e p, input logic [15:0] d);
        ctl.xfer(c, s[0], p, d);
    endtask : wr
    task automatic rd(input srh_cmd_e c, input int s, input srh_part_e p, input logic [15:0] e);
        ctl.xfer(c, s[0], p, 16'h0000);
        check("rvalid", {15'h0000, ctl.last_rvalid}, 16'h0001);
        check(c.name(), ctl.last_rdata, e);
    endtask : rd
    task automatic pulse_entry();
        een = 1'b1;
        tick(1);
        een = 1'b0;
        tick(3);
    endtask : pulse_entry
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // watchdog against a hung handshake
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    // main sequence
    initial begin
        rstn_i = 1'b0;
        cond = '0;
        sev = 8'h00;
        eqn = 1'b0;
        een = 1'b0;
        omp = 1'b0;
        repeat (16) @(posedge ref_clk_i);
        #1;
        rstn_i = 1'b1;
        check("byte_rst", {8'h00, byte_o}, 16'h0000);
        check("srq_rst", {15'h0000, srq_o}, 16'h0000);
        rd(CMD_SRQ_MASK_RD, 0, PART_COND, 16'h0000);
        rd(CMD_STD_MASK_RD, 0, PART_COND, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            rd(CMD_SUB_RD, s, PART_RISE, 16'h7fff);
            rd(CMD_SUB_RD, s, PART_FALL, 16'h0000);
            rd(CMD_SUB_RD, s, PART_ENABLE, 16'h0000);
            rd(CMD_SUB_RD, s, PART_EVENT, 16'h0000);
        end
        wr(CMD_SUB_WR, 0, PART_FALL, 16'hffff);
        rd(CMD_SUB_RD, 0, PART_FALL, 16'h7fff);
        wr(CMD_SUB_WR, 0, PART_COND, 16'h1234);
        rd(CMD_SUB_RD, 0, PART_COND, 16'h0000);
        // ordinary status byte cases
        foreach (rows[i]) begin
            wr(CMD_SRQ_MASK_WR, 0, PART_COND, {8'h00, rows[i].mask});
            omp = rows[i].msg;
            eqn = rows[i].errq;
            tick(3);
            check("byte", {8'h00, byte_o}, {8'h00, rows[i].exp_byte});
            check("srq", {15'h0000, srq_o}, {15'h0000, rows[i].exp_srq});
            rd(CMD_SRQ_MASK_RD, 0, PART_COND, {8'h00, rows[i].mask});
            omp = 1'b0;
            eqn = 1'b0;
            tick(3);
            check("srq_drop", {15'h0000, srq_o}, 16'h0000);
        end
        // every filter mode on both sub-registers
        // write then query on consecutive edges
        ctl.xfer2(CMD_SRQ_MASK_WR, CMD_SRQ_MASK_RD, 16'h00a5);
        check("b2b_rvalid", {15'h0000, ctl.last_rvalid}, 16'h0001);
        check("b2b_mask", ctl.last_rdata, 16'h00a5);
        wr(CMD_SRQ_MASK_WR, 0, PART_COND, 16'h0000);
        for (int s = 0; s < 2; s++) begin
            wr(CMD_SUB_WR, s, PART_ENABLE, 16'h0001);
            rd(CMD_SUB_RD, s, PART_ENABLE, 16'h0001);
            for (int m = 0; m < 4; m++) begin
                wr(CMD_SUB_WR, s, PART_RISE, {15'h0000, m[0]});
                wr(CMD_SUB_WR, s, PART_FALL, {15'h0000, m[1]});
                cond[s][0] = 1'b1;
                tick(4);
                rd(CMD_SUB_RD, s, PART_COND, 16'h0001);
                check("sum_bit", {15'h0000, byte_o[s ? 7 : 3]}, {15'h0000, m[0]});
                rd(CMD_SUB_RD, s, PART_EVENT, {15'h0000, m[0]});
                rd(CMD_SUB_RD, s, PART_EVENT, 16'h0000);
                tick(3);
                check("sum_clr", {15'h0000, byte_o[s ? 7 : 3]}, 16'h0000);
                cond[s][0] = 1'b0;
                tick(4);
                rd(CMD_SUB_RD, s, PART_EVENT, {15'h0000, m[1]});
            end
        end
        // standard event summary
        wr(CMD_STD_MASK_WR, 0, PART_COND, 16'h0001);
        rd(CMD_STD_MASK_RD, 0, PART_COND, 16'h0001);
        sev = 8'h02;
        tick(1);
        sev = 8'h00;
        tick(3);
        check("std_masked", {15'h0000, byte_o[5]}, 16'h0000);
        sev = 8'h01;
        tick(1);
        sev = 8'h00;
        tick(3);
        check("std_sum", {15'h0000, byte_o[5]}, 16'h0001);
        rd(CMD_STD_EVENT_RD, 0, PART_COND, 16'h0003);
        rd(CMD_STD_EVENT_RD, 0, PART_COND, 16'h0000);
        tick(3);
        check("std_clr", {15'h0000, byte_o[5]}, 16'h0000);
        // error queue requests, query and serial poll
        wr(CMD_SRQ_MASK_WR, 0, PART_COND, 16'h0004);
        eqn = 1'b1;
        pulse_entry();
        check("srq_err", {15'h0000, srq_o}, 16'h0001);
        rd(CMD_BYTE_RD, 0, PART_COND, 16'h0044);
        check("srq_query", {15'h0000, srq_o}, 16'h0001);
        ctl.poll_delay = 5;
        ctl.auto_poll = 1'b1;
        for (int k = 0; k < 30 && srq_o !== 1'b0; k++) begin
            tick(1);
        end
        tick(2);
        ctl.auto_poll = 1'b0;
        check("polled", {8'h00, ctl.polled_byte}, 16'h0044);
        tick(3);
        check("srq_hold", {15'h0000, srq_o}, 16'h0000);
        pulse_entry();
        check("srq_again", {15'h0000, srq_o}, 16'h0001);
        rd(CMD_SERIAL_POLL, 0, PART_COND, 16'h0044);
        check("srq_poll", {15'h0000, srq_o}, 16'h0000);
        eqn = 1'b0;
        tick(3);
        print_verdict();
    end
endmodule : testbench
